// >>> verilog/pwm_pkg.sv
// Package of offsets, field positions and reset values for the PWM block
package pwm_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W       = 8;
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_PERIOD   = 8'h04;
    localparam logic [7:0]  OFF_DUTY_WR  = 8'h08;
    localparam logic [7:0]  OFF_DUTY_BUF = 8'h0C;
    localparam logic [7:0]  OFF_BRIDGE   = 8'h10;
    localparam logic [7:0]  OFF_DIR      = 8'h14;
    localparam logic [7:0]  OFF_STATUS   = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_EN      = 0;
    localparam int unsigned CTRL_HB      = 1;
    localparam int unsigned CTRL_PS_LO   = 2;
    localparam int unsigned CTRL_DLOW_LO = 4;
    localparam int unsigned STAT_PRI     = 10;
    localparam int unsigned STAT_SEC     = 11;
    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [5:0]  CTRL_RST     = 6'h00;
    localparam logic [7:0]  PERIOD_RST   = 8'hFF;
    localparam logic [6:0]  BRIDGE_RST   = 7'h00;
    localparam logic [1:0]  DIR_RST      = 2'h3;
    localparam logic [1:0]  PS_DIV1      = 2'h0;
    localparam logic [1:0]  PS_DIV4      = 2'h1;
    localparam logic [3:0]  PS4_LAST     = 4'h3;
    localparam logic [3:0]  PS16_LAST    = 4'hF;
    localparam int unsigned OSC_PER_INSTR = 4;
    localparam logic [1:0]  Q_LAST       = 2'(OSC_PER_INSTR - 1);
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// >>> verilog/pwm_halfbridge.sv
// PWM generator with double-buffered duty, half-bridge dead band, AXI4-Lite registers
//
// Contract
// - Period is (period+1) x 4 x prescale clocks
// - Timer clears on increment after period match
// - Output set at restart unless duty zero
// - Duty buffer loads at period match, or by write while stopped
// - No postscaler affects PWM frequency
// - Duty is duty_high_write with two low bits
// - Duty writes anytime, no effect mid-period
// - Duty buffer read-only while PWM runs
// - Buffer plus 2-bit latch double-buffer duty
// - Time base is timer plus two sub-bits
// - Time base equal duty clears output
// - Duty beyond period leaves output unchanged
// - Full ten-bit resolution at period 255
// - Prescaler divides by 1, 4, 16
// - Half-bridge gives output and its complement
// - Dead band delays active edge instr cycles
// - Dead band above duty keeps output inactive
// - Instruction cycle is four oscillator clocks
`timescale 1ns/100ps
module pwm_halfbridge (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire logic [pwm_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input  wire logic                       i_s_axi_awvalid,
    output logic                            o_s_axi_awready,
    input  wire logic [31:0]                i_s_axi_wdata,
    input  wire logic [3:0]                 i_s_axi_wstrb,
    input  wire logic                       i_s_axi_wvalid,
    output logic                            o_s_axi_wready,
    output logic [1:0]                      o_s_axi_bresp,
    output logic                            o_s_axi_bvalid,
    input  wire logic                       i_s_axi_bready,
    input  wire logic [pwm_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input  wire logic                       i_s_axi_arvalid,
    output logic                            o_s_axi_arready,
    output logic [31:0]                     o_s_axi_rdata,
    output logic [1:0]                      o_s_axi_rresp,
    output logic                            o_s_axi_rvalid,
    input  wire logic                       i_s_axi_rready,
    output logic                            o_primary_output,
    output logic                            o_primary_oe,
    output logic                            o_secondary_output,
    output logic                            o_secondary_oe
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == pwm_pkg::OFF_CTRL)    || (a == pwm_pkg::OFF_PERIOD)
               || (a == pwm_pkg::OFF_DUTY_WR) || (a == pwm_pkg::OFF_DUTY_BUF)
               || (a == pwm_pkg::OFF_BRIDGE)  || (a == pwm_pkg::OFF_DIR)
               || (a == pwm_pkg::OFF_STATUS);
    endfunction

    // Dead-band counter step: restarts whenever the raw level drops
    function automatic logic [6:0] db_step(input logic [6:0] cnt, input logic raw,
                                           input logic [6:0] dead, input logic tick);
        if (!raw) begin
            db_step = 7'h00;
        end else if (tick && cnt < dead) begin
            db_step = cnt + 7'h01;
        end else begin
            db_step = cnt;
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0]  ctrl_q;
    logic [7:0]  period_q, duty_wr_q, duty_buf_q, timer_q;
    logic [1:0]  duty_lat_q, dir_q, q_q;
    logic [6:0]  dead_q, pri_cnt_q, sec_cnt_q;
    logic [3:0]  ps_q;
    logic        pwm_q, pri_q, sec_q;
    logic        aw_hold_q, w_hold_q, wstrb0_q, bvalid_q, rvalid_q;
    logic [7:0]  awaddr_q, wdata_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q, rd_mux;
    logic        en, hb, instr_tick, timer_tick, restart, wr_go, wr_en;
    logic [1:0]  ps_sel, tb_low;
    logic [3:0]  ps_last;
    logic [9:0]  time_base, duty_new;
    logic [6:0]  pri_dead;
    logic        sec_raw, pwm_lvl;

    assign en     = ctrl_q[pwm_pkg::CTRL_EN];
    assign hb     = ctrl_q[pwm_pkg::CTRL_HB];
    assign ps_sel = ctrl_q[pwm_pkg::CTRL_PS_LO +: 2];

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    assign o_s_axi_awready = !aw_hold_q;
    assign o_s_axi_wready  = !w_hold_q;
    assign o_s_axi_bvalid  = bvalid_q;
    assign o_s_axi_bresp   = bresp_q;
    assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_en = wr_go && wstrb0_q && addr_ok(awaddr_q);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 8'h00;
            wstrb0_q  <= 1'b0;
        end else begin
            if (i_s_axi_awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= i_s_axi_awaddr[7:0];
            end else if (wr_go) begin
                aw_hold_q <= 1'b0;
            end
            if (i_s_axi_wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                wdata_q  <= i_s_axi_wdata[7:0];
                wstrb0_q <= i_s_axi_wstrb[0];
            end else if (wr_go) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= pwm_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_ok(awaddr_q) ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
        end else if (i_s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Duty bytes accepted at any time; they only reach the compare at restart
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q    <= pwm_pkg::CTRL_RST;
            period_q  <= pwm_pkg::PERIOD_RST;
            duty_wr_q <= 8'h00;
            dead_q    <= pwm_pkg::BRIDGE_RST;
            dir_q     <= pwm_pkg::DIR_RST;
        end else if (wr_en) begin
            unique case (awaddr_q)
                pwm_pkg::OFF_CTRL:    ctrl_q    <= wdata_q[5:0];
                pwm_pkg::OFF_PERIOD:  period_q  <= wdata_q;
                pwm_pkg::OFF_DUTY_WR: duty_wr_q <= wdata_q;
                pwm_pkg::OFF_BRIDGE:  dead_q    <= wdata_q[6:0];
                pwm_pkg::OFF_DIR:     dir_q     <= wdata_q[1:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    assign o_s_axi_arready = !rvalid_q;
    assign o_s_axi_rvalid  = rvalid_q;
    assign o_s_axi_rresp   = rresp_q;
    assign o_s_axi_rdata   = rdata_q;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_s_axi_araddr[7:0])
            pwm_pkg::OFF_CTRL:     rd_mux[5:0] = ctrl_q;
            pwm_pkg::OFF_PERIOD:   rd_mux[7:0] = period_q;
            pwm_pkg::OFF_DUTY_WR:  rd_mux[7:0] = duty_wr_q;
            pwm_pkg::OFF_DUTY_BUF: rd_mux[7:0] = duty_buf_q;
            pwm_pkg::OFF_BRIDGE:   rd_mux[6:0] = dead_q;
            pwm_pkg::OFF_DIR:      rd_mux[1:0] = dir_q;
            pwm_pkg::OFF_STATUS: begin
                rd_mux[9:0]               = time_base;
                rd_mux[pwm_pkg::STAT_PRI] = pri_q;
                rd_mux[pwm_pkg::STAT_SEC] = sec_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= pwm_pkg::RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (i_s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= addr_ok(i_s_axi_araddr[7:0]) ? pwm_pkg::RESP_OKAY
                                                     : pwm_pkg::RESP_SLVERR;
        end else if (i_s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Instruction cycle and prescaler
    // ------------------------------------------------------------
    // Held at zero while disabled so the first period starts aligned
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q_q <= 2'h0;
        end else if (!en) begin
            q_q <= 2'h0;
        end else begin
            q_q <= q_q + 2'h1;
        end
    end
    assign instr_tick = en && (q_q == pwm_pkg::Q_LAST);

    always_comb begin
        unique case (ps_sel)
            pwm_pkg::PS_DIV1: ps_last = 4'h0;
            pwm_pkg::PS_DIV4: ps_last = pwm_pkg::PS4_LAST;
            default:          ps_last = pwm_pkg::PS16_LAST;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ps_q <= 4'h0;
        end else if (!en) begin
            ps_q <= 4'h0;
        end else if (instr_tick) begin
            ps_q <= (ps_q == ps_last) ? 4'h0 : ps_q + 4'h1;
        end
    end
    // Timer output goes straight to the PWM; no postscaler in the path
    assign timer_tick = instr_tick && (ps_q == ps_last);

    // ------------------------------------------------------------
    // Timer, time base and duty buffer
    // ------------------------------------------------------------
    assign restart = timer_tick && (timer_q == period_q);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            timer_q <= 8'h00;
        end else if (!en) begin
            timer_q <= 8'h00;
        end else if (restart) begin
            timer_q <= 8'h00;
        end else if (timer_tick) begin
            timer_q <= timer_q + 8'h01;
        end
    end

    always_comb begin
        unique case (ps_sel)
            pwm_pkg::PS_DIV1: tb_low = q_q;
            pwm_pkg::PS_DIV4: tb_low = ps_q[1:0];
            default:          tb_low = ps_q[3:2];
        endcase
    end
    // Ten bits give 1024 steps only when the period spans all 256 counts
    assign time_base = {timer_q, tb_low};
    assign duty_new  = {duty_wr_q, ctrl_q[pwm_pkg::CTRL_DLOW_LO +: 2]};

    // Buffer writable only while stopped; the running compare never sees a write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            duty_buf_q <= 8'h00;
            duty_lat_q <= 2'h0;
        end else if (restart) begin
            duty_buf_q <= duty_new[9:2];
            duty_lat_q <= duty_new[1:0];
        end else if (wr_en && !en && awaddr_q == pwm_pkg::OFF_DUTY_BUF) begin
            duty_buf_q <= wdata_q;
        end
    end

    // ------------------------------------------------------------
    // PWM level
    // ------------------------------------------------------------
    // A duty past the period never matches, so the level simply stays
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pwm_q <= 1'b0;
        end else if (!en) begin
            pwm_q <= 1'b0;
        end else if (restart) begin
            pwm_q <= (duty_new != 10'h000);
        end else if (time_base == {duty_buf_q, duty_lat_q}) begin
            pwm_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Dead band and pin drive
    // ------------------------------------------------------------
    // Outside half-bridge the primary follows the PWM with no delay
    assign pri_dead = hb ? dead_q : 7'h00;
    // Low from the first matching count, so the width is exactly duty counts
    assign pwm_lvl  = pwm_q && (time_base != {duty_buf_q, duty_lat_q});
    assign sec_raw  = hb && en && !pwm_lvl;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pri_cnt_q <= 7'h00;
            pri_q     <= 1'b0;
        end else begin
            pri_cnt_q <= db_step(pri_cnt_q, pwm_lvl, pri_dead, instr_tick);
            pri_q     <= pwm_lvl && (pri_cnt_q >= pri_dead);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sec_cnt_q <= 7'h00;
            sec_q     <= 1'b0;
        end else begin
            sec_cnt_q <= db_step(sec_cnt_q, sec_raw, dead_q, instr_tick);
            sec_q     <= sec_raw && (sec_cnt_q >= dead_q);
        end
    end

    assign o_primary_output   = pri_q;
    assign o_secondary_output = sec_q;
    // Pins stay released until software clears their direction bits; the secondary also needs half-bridge mode
    assign o_primary_oe       = !dir_q[0];
    assign o_secondary_oe     = !dir_q[1] && hb;
endmodule

// >>> bench/pwm_halfbridge_monitor.sv
// Checker of bus handshakes and output relations of the PWM block
`timescale 1ns/100ps
module pwm_halfbridge_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic        i_s_axi_wvalid,
    input wire logic        o_s_axi_wready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready,
    input wire logic        o_primary_output,
    input wire logic        o_secondary_output
);
    // ------------------------------------------------------------
    // Handshake steps
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_wr_taken;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
    endsequence
    sequence s_rd_taken;
        i_s_axi_arvalid && o_s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##2 o_s_axi_bvalid)
        else $error("write not answered in two cycles");
    a_write_refused: assert property (s_wr_taken |=> !o_s_axi_awready && !o_s_axi_wready)
        else $error("new write accepted before response");
    a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped or changed");
    a_bresp_drop: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
        else $error("write response repeated");
    a_read_answer: assert property (s_rd_taken |=> o_s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("read data dropped or changed");
    a_read_drop: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
        else $error("read data repeated");
    a_outputs_apart: assert property (!(o_primary_output && o_secondary_output))
        else $error("both bridge outputs active");
endmodule

bind pwm_halfbridge pwm_halfbridge_monitor i_pwm_halfbridge_monitor (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
    .o_primary_output(o_primary_output), .o_secondary_output(o_secondary_output)
);

// >>> bench/pwm_power_stage.sv
// Behavioural push-pull half-bridge stage loaded by the two PWM outputs
`timescale 1ns/100ps
module pwm_power_stage (
    input  wire logic i_clk,
    input  wire logic i_high_on,
    input  wire logic i_high_oe,
    input  wire logic i_low_on,
    input  wire logic i_low_oe,
    output logic      o_node,
    output int        o_shoots
);
    initial o_shoots = 0;
    initial o_node = 1'b0;
    always @(posedge i_clk) begin
        if (i_high_oe && i_high_on && i_low_oe && i_low_on) begin
            o_shoots <= o_shoots + 1;
        end
        if (i_high_oe && i_high_on) begin
            o_node <= 1'b1;
        end else if (i_low_oe && i_low_on) begin
            o_node <= 1'b0;
        end else begin
            // Floating node toggles so a stale level never passes
            o_node <= ~o_node;
        end
    end
endmodule

// >>> bench/pwm_halfbridge_bench.sv
// Self-checking bench of the PWM block over AXI4-Lite
`timescale 1ns/100ps
module pwm_halfbridge_bench;
    logic        clk = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pri, pri_oe, sec, sec_oe;
    logic [1:0]  bresp, rresp;
    int          num_errors = 0, samples_checked = 0, cycles = 0, shoots;
    integer      seed = 32'hf74e;
    logic [31:0] rst_val [8] = '{32'(pwm_pkg::CTRL_RST), 32'(pwm_pkg::PERIOD_RST), 32'h0,
                                 32'h0, 32'(pwm_pkg::BRIDGE_RST), 32'(pwm_pkg::DIR_RST), 32'h0, 32'h0};
    always #50 clk = ~clk;
    pwm_halfbridge i_pwm_halfbridge (.i_clk(clk), .i_rst(rst), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .o_primary_output(pri), .o_primary_oe(pri_oe),
        .o_secondary_output(sec), .o_secondary_oe(sec_oe));
    pwm_power_stage i_pwm_power_stage (.i_clk(clk), .i_high_on(pri), .i_high_oe(pri_oe),
        .i_low_on(sec), .i_low_oe(sec_oe), .o_node(), .o_shoots(shoots));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Ceiling well above the longest random period set
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er = pwm_pkg::RESP_OKAY);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 200);
        bready <= 1'b0;
        check(32'(bresp), 32'(er));
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er = pwm_pkg::RESP_OKAY);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 200);
        rready <= 1'b0;
        check(rdata, exp);
        check(32'(rresp), 32'(er));
    endtask
    function automatic int div_of(input int k);
        return (k == 0) ? 1 : (k == 1) ? 4 : 16;
    endfunction
    function automatic logic [31:0] ctrl_of(input logic hb, input int k, input int d);
        return 32'({d[1:0], k[1:0], hb, 1'b1});
    endfunction
    // Dead band start may slip up to one instruction cycle on alignment
    function automatic logic near(input int seen, input int exp);
        return seen <= exp + 1 && seen >= exp - 4;
    endfunction
    task automatic cfg(input int p, input int d, input int k, input logic hb, input int db);
        axi_wr(pwm_pkg::OFF_CTRL, 32'h0000_0000);
        axi_wr(pwm_pkg::OFF_DIR, 32'h0000_0000);
        axi_wr(pwm_pkg::OFF_PERIOD, 32'(p));
        axi_wr(pwm_pkg::OFF_DUTY_WR, 32'(d >> 2));
        axi_wr(pwm_pkg::OFF_BRIDGE, 32'(db));
        axi_wr(pwm_pkg::OFF_CTRL, ctrl_of(hb, k, d));
    endtask
    task automatic measure(output int hi, output int per);
        hi = 0;
        per = 0;
        do @(posedge clk); while (pri);
        do @(posedge clk); while (!pri);
        do begin hi++; per++; @(posedge clk); end while (pri);
        do begin per++; @(posedge clk); end while (!pri);
    endtask
    task automatic count_high(input int n, input logic sel, output int hi);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            hi += ((sel ? sec : pri) === 1'b1);
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int p, d1, d2, k, hi, per;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'(4 * i), rst_val[i], i == 7 ? pwm_pkg::RESP_SLVERR : pwm_pkg::RESP_OKAY);
        end
        axi_wr(8'h1C, 32'h0000_0001, pwm_pkg::RESP_SLVERR);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            k  = i % 3;
            p  = (i == 0) ? 255 : 10 + ($unsigned($random(seed)) % 6);
            d1 = 24 + ($unsigned($random(seed)) % (4 * p - 26));
            d2 = 2 + ($unsigned($random(seed)) % (4 * p));
            cfg(p, d1, k, 1'b0, 0);
            fork
                measure(hi, per);
                begin
                    @(posedge pri);
                    axi_wr(pwm_pkg::OFF_DUTY_WR, 32'(d2 >> 2));
                    axi_wr(pwm_pkg::OFF_CTRL, ctrl_of(1'b0, k, d2));
                end
            join
            check(32'(hi), 32'(d1 * div_of(k)));
            check(32'(per), 32'((p + 1) * 4 * div_of(k)));
            measure(hi, per);
            check(32'(hi), 32'(d2 * div_of(k)));
            axi_wr(pwm_pkg::OFF_DUTY_BUF, 32'h0000_005A);
            rd_chk(pwm_pkg::OFF_DUTY_BUF, 32'(d2 >> 2));
            $display("test random period %0d done", i);
        end
        cfg(10, 0, 0, 1'b0, 0);
        count_high(132, 1'b0, hi);
        check(32'(hi), 32'h0000_0000);
        cfg(10, 1023, 0, 1'b0, 0);
        repeat (50) @(posedge clk);
        count_high(132, 1'b0, hi);
        check(32'(hi), 32'h0000_0084);
        $display("test duty limits done");
        cfg(15, 32, 0, 1'b1, 3);
        check(32'({pri_oe, sec_oe}), 32'h0000_0003);
        measure(hi, per);
        check(32'(near(hi, 32 - 4 * 3)), 32'h0000_0001);
        check(32'(per), 32'h0000_0040);
        count_high(64, 1'b1, hi);
        check(32'(near(hi, 32 - 4 * 3)), 32'h0000_0001);
        cfg(15, 32, 0, 1'b1, 10);
        count_high(192, 1'b0, hi);
        check(32'(hi), 32'h0000_0000);
        check(32'(shoots), 32'h0000_0000);
        $display("test half bridge done");
        tally_and_finish();
    end
endmodule
